// >>> inc/smr_pkg.sv
// Constants for the state-machine result register bank.
// Assumes a 40 MHz bus clock and a 32-bit AHB-Lite register bus.
package smr_pkg;

    // ----------------------------------------------------------------
    // Clock and rate timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 40_000_000;
    // Rates in half-hertz so that 12.5 Hz stays an integer
    localparam int unsigned RATE_HALF_HZ_00 = 25;
    localparam int unsigned RATE_HALF_HZ_01 = 52;
    localparam int unsigned RATE_HALF_HZ_10 = 104;
    localparam int unsigned RATE_HALF_HZ_11 = 208;
    localparam int unsigned EVAL_CYC_00 = (2 * CLK_HZ) / RATE_HALF_HZ_00;
    localparam int unsigned EVAL_CYC_01 = (2 * CLK_HZ) / RATE_HALF_HZ_01;
    localparam int unsigned EVAL_CYC_10 = (2 * CLK_HZ) / RATE_HALF_HZ_10;
    localparam int unsigned EVAL_CYC_11 = (2 * CLK_HZ) / RATE_HALF_HZ_11;
    localparam int CNT_W = 22;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_M11 = 8'h56;
    localparam logic [7:0] IDX_M12 = 8'h57;
    localparam logic [7:0] IDX_M13 = 8'h58;
    localparam logic [7:0] IDX_M14 = 8'h59;
    localparam logic [7:0] IDX_M15 = 8'h5A;
    localparam logic [7:0] IDX_M16 = 8'h5B;
    localparam logic [7:0] IDX_CFG = 8'h5F;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h70;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h71;
    localparam int ADDR_W = 10;
    localparam int NUM_MACH = 6;

    // ----------------------------------------------------------------
    // Result byte layout
    // ----------------------------------------------------------------
    localparam int BIT_PX = 7;
    localparam int BIT_NX = 6;
    localparam int BIT_PY = 5;
    localparam int BIT_NY = 4;
    localparam int BIT_PZ = 3;
    localparam int BIT_NZ = 2;
    localparam int BIT_PV = 1;
    localparam int BIT_NV = 0;

    // ----------------------------------------------------------------
    // Rate configuration layout and reset values
    // ----------------------------------------------------------------
    localparam int RATE_LSB = 0;
    localparam int RATE_W = 2;
    localparam logic [1:0] RATE_12HZ5 = 2'h0;
    localparam logic [1:0] RATE_26HZ = 2'h1;
    localparam logic [1:0] RATE_52HZ = 2'h2;
    localparam logic [1:0] RATE_104HZ = 2'h3;
    localparam logic [7:0] CFG_RST = 8'h01;
    localparam logic [7:0] RESULT_RST = 8'h00;
    localparam logic [5:0] IRQ_RST = 6'h00;

    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

endpackage : smr_pkg

// >>> hdl/smr_rate_tick.sv
// Evaluation tick divider for the state-machine engine.
// Assumes one clock; the tick is a one-cycle enable pulse.
`timescale 1ns/100ps
`default_nettype none

module smr_rate_tick #(
    parameter int unsigned CYC_00 = smr_pkg::EVAL_CYC_00,
    parameter int unsigned CYC_01 = smr_pkg::EVAL_CYC_01,
    parameter int unsigned CYC_10 = smr_pkg::EVAL_CYC_10,
    parameter int unsigned CYC_11 = smr_pkg::EVAL_CYC_11
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Rate selection
    input wire logic [1:0] rate_sel,
    // Evaluation enable
    output logic tick
);

    logic [smr_pkg::CNT_W-1:0] cnt_r;
    logic [smr_pkg::CNT_W-1:0] period;
    logic [1:0] rate_prev_r;

    always_comb begin
        case (rate_sel)
            smr_pkg::RATE_12HZ5: period = smr_pkg::CNT_W'(CYC_00);
            smr_pkg::RATE_26HZ: period = smr_pkg::CNT_W'(CYC_01);
            smr_pkg::RATE_52HZ: period = smr_pkg::CNT_W'(CYC_10);
            default: period = smr_pkg::CNT_W'(CYC_11);
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rate_prev_r <= smr_pkg::RATE_26HZ;
        end else begin
            rate_prev_r <= rate_sel;
        end
    end

    // A new rate restarts the period so no stale long count lingers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= '0;
            tick <= 1'b0;
        end else if (rate_prev_r != rate_sel) begin
            cnt_r <= '0;
            tick <= 1'b0;
        end else if (cnt_r >= period - 1'b1) begin
            cnt_r <= '0;
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 1'b1;
            tick <= 1'b0;
        end
    end

endmodule : smr_rate_tick

`default_nettype wire

// >>> hdl/smr_result_regs.sv
// Result register bank for state machines 11 to 16 with rate config.
// Assumes a single AHB-Lite master and an engine that reports flags
// with a done pulse after each evaluation tick.
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Six read-only result bytes, consecutive indices
// - Bit order PX NX PY NY PZ NZ PV NV
// - Axis flag one when event detected
// - Vector flags one when vector event detected
// - Separate read/write rate configuration register
// - Rate code selects 12.5/26/52/104 Hz
// - Rate code resets to 01, 26 Hz
module smr_result_regs #(
    parameter int unsigned CYC_00 = smr_pkg::EVAL_CYC_00,
    parameter int unsigned CYC_01 = smr_pkg::EVAL_CYC_01,
    parameter int unsigned CYC_10 = smr_pkg::EVAL_CYC_10,
    parameter int unsigned CYC_11 = smr_pkg::EVAL_CYC_11,
    parameter int NUM_MACH = smr_pkg::NUM_MACH
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [smr_pkg::ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // State-machine engine
    input wire logic [8*NUM_MACH-1:0] eng_flags,
    input wire logic eng_done,
    output logic eval_tick,
    output logic [1:0] machine_rate_select,
    // Interrupt
    output logic irq
);

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    function automatic logic idx_hit(
        input logic [smr_pkg::ADDR_W-1:0] a,
        input logic [7:0] idx
    );
        idx_hit = (a == {idx, 2'b00});
    endfunction : idx_hit

    function automatic int result_slot(
        input logic [smr_pkg::ADDR_W-1:0] a
    );
        int slot;
        slot = -1;
        for (int i = 0; i < NUM_MACH; i++) begin
            if (idx_hit(a, smr_pkg::IDX_M11 + 8'(i))) begin
                slot = i;
            end
        end
        result_slot = slot;
    endfunction : result_slot

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [7:0] result_r [NUM_MACH];
    logic [7:0] cfg_r;
    logic [NUM_MACH-1:0] irq_stat_r;
    logic [NUM_MACH-1:0] irq_mask_r;
    logic wr_pend_r;
    logic [smr_pkg::ADDR_W-1:0] wr_addr_r;
    logic [NUM_MACH-1:0] new_event;
    logic [NUM_MACH-1:0] stat_clr;
    logic accept;
    logic tick;

    assign accept = hsel && hready && (htrans == smr_pkg::HTRANS_NONSEQ);

    // ----------------------------------------------------------------
    // Bus response: zero wait states, always OKAY
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp <= smr_pkg::HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp <= smr_pkg::HRESP_OKAY;
        end
    end

    // Write address phase captured, data taken one edge later
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= '0;
        end else if (hready) begin
            wr_pend_r <= accept && hwrite;
            wr_addr_r <= haddr;
        end
    end

    // ----------------------------------------------------------------
    // Read data, registered at the address phase
    // ----------------------------------------------------------------
    // The master idles during each data phase, so a read never meets
    // a write still pending to the same register.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (accept && !hwrite) begin
            if (result_slot(haddr) >= 0) begin
                hrdata <= {24'h000000, result_r[result_slot(haddr)]};
            end else if (idx_hit(haddr, smr_pkg::IDX_CFG)) begin
                hrdata <= {24'h000000, cfg_r};
            end else if (idx_hit(haddr, smr_pkg::IDX_IRQ_STAT)) begin
                hrdata <= {{(32-NUM_MACH){1'b0}}, irq_stat_r};
            end else if (idx_hit(haddr, smr_pkg::IDX_IRQ_MASK)) begin
                hrdata <= {{(32-NUM_MACH){1'b0}}, irq_mask_r};
            end else begin
                hrdata <= '0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Rate configuration
    // ----------------------------------------------------------------
    // Whole byte is stored; software must keep the fixed bits as
    // reset leaves them, the block does not police them.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_r <= smr_pkg::CFG_RST;
        end else if (wr_pend_r && idx_hit(wr_addr_r, smr_pkg::IDX_CFG)) begin
            cfg_r <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            machine_rate_select <= smr_pkg::RATE_26HZ;
        end else begin
            machine_rate_select <=
                cfg_r[smr_pkg::RATE_LSB +: smr_pkg::RATE_W];
        end
    end

    // ----------------------------------------------------------------
    // Evaluation rate divider
    // ----------------------------------------------------------------
    smr_rate_tick #(
        .CYC_00(CYC_00),
        .CYC_01(CYC_01),
        .CYC_10(CYC_10),
        .CYC_11(CYC_11)
    ) u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .rate_sel(machine_rate_select),
        .tick(tick)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            eval_tick <= 1'b0;
        end else begin
            eval_tick <= tick;
        end
    end

    // ----------------------------------------------------------------
    // Result bytes, one per machine
    // ----------------------------------------------------------------
    // Bus writes never reach these; only the engine's done pulse does.
    genvar g;
    generate
        for (g = 0; g < NUM_MACH; g++) begin : g_mach
            logic [7:0] fl;
            assign fl = eng_flags[8*g +: 8];
            assign new_event[g] = eng_done && (fl != 8'h00)
                                  && (result_r[g] == 8'h00);
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    result_r[g] <= smr_pkg::RESULT_RST;
                end else if (eng_done) begin
                    result_r[g] <= {fl[smr_pkg::BIT_PX], fl[smr_pkg::BIT_NX],
                                    fl[smr_pkg::BIT_PY], fl[smr_pkg::BIT_NY],
                                    fl[smr_pkg::BIT_PZ], fl[smr_pkg::BIT_NZ],
                                    fl[smr_pkg::BIT_PV], fl[smr_pkg::BIT_NV]};
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Interrupt status and mask
    // ----------------------------------------------------------------
    assign stat_clr = (wr_pend_r && idx_hit(wr_addr_r, smr_pkg::IDX_IRQ_STAT))
                      ? hwdata[NUM_MACH-1:0] : '0;

    // New event wins over a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_r <= smr_pkg::IRQ_RST[NUM_MACH-1:0];
        end else begin
            irq_stat_r <= (irq_stat_r & ~stat_clr) | new_event;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask_r <= smr_pkg::IRQ_RST[NUM_MACH-1:0];
        end else if (wr_pend_r
                     && idx_hit(wr_addr_r, smr_pkg::IDX_IRQ_MASK)) begin
            irq_mask_r <= hwdata[NUM_MACH-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_r & irq_mask_r);
        end
    end

endmodule : smr_result_regs

`default_nettype wire

// >>> dv/smr_result_regs_props.sv
// Checker for the state-machine result register bank.
// Assumes hready is looped back from hreadyout, one master.
`timescale 1ns/100ps
`default_nettype none
module smr_result_regs_props #(
    parameter int unsigned CYC_00 = 20,
    parameter int unsigned CYC_01 = 10,
    parameter int unsigned CYC_10 = 6,
    parameter int unsigned CYC_11 = 4
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [smr_pkg::ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    // Engine and interrupt
    input wire logic [8*smr_pkg::NUM_MACH-1:0] eng_flags,
    input wire logic eng_done,
    input wire logic eval_tick,
    input wire logic [1:0] machine_rate_select,
    input wire logic irq
);
    // ----------
    // Reference state
    // ----------
    logic rd, wr, chg, cfg_wr_q;
    logic [7:0] ix, rbyte, cfg_q;
    logic [47:0] flg_q;
    logic [1:0] rs_q, tcnt;
    logic [23:0] gap;
    int unsigned cyc;
    assign rd = hsel && hready && htrans == smr_pkg::HTRANS_NONSEQ
        && !hwrite;
    assign wr = hsel && hready && htrans == smr_pkg::HTRANS_NONSEQ
        && hwrite;
    assign ix = haddr[9:2];
    assign rbyte = 8'(flg_q >> (8 * (ix - smr_pkg::IDX_M11)));
    assign chg = machine_rate_select != rs_q;
    assign cyc = machine_rate_select == 2'h0 ? CYC_00 :
        machine_rate_select == 2'h1 ? CYC_01 :
        machine_rate_select == 2'h2 ? CYC_10 : CYC_11;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flg_q <= '0;
            cfg_q <= 8'h01;
            cfg_wr_q <= 1'b0;
        end else begin
            if (eng_done)
                flg_q <= eng_flags;
            cfg_wr_q <= wr && ix == smr_pkg::IDX_CFG;
            if (cfg_wr_q)
                cfg_q <= hwdata[7:0];
        end
    end
    // Judge each tick from the third after a rate change on: restart lag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rs_q <= 2'h1;
            tcnt <= 2'h0;
            gap <= 24'h0;
        end else begin
            rs_q <= machine_rate_select;
            gap <= eval_tick ? 24'h0 : gap + 24'h1;
            if (chg)
                tcnt <= 2'h0;
            else if (eval_tick && tcnt != 2'h2)
                tcnt <= tcnt + 2'h1;
        end
    end
    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_res_rd;
        rd && ix >= smr_pkg::IDX_M11 && ix <= smr_pkg::IDX_M16
            && !eng_done;
    endsequence
    sequence s_cfg_rd;
        rd && ix == smr_pkg::IDX_CFG;
    endsequence
    a_result_read: assert property (
        s_res_rd |=> hrdata == {24'h0, $past(rbyte)})
        else $error("result byte read differs");
    a_cfg_read: assert property (
        s_cfg_rd |=> hrdata == {24'h0, $past(cfg_q)})
        else $error("rate config read differs");
    a_unmapped_zero: assert property (
        rd && ix < smr_pkg::IDX_M11 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    // Rate select is a flop behind the config byte: one cycle of lag
    a_rate_follow: assert property (
        machine_rate_select == $past(cfg_q[1:0]))
        else $error("rate select differs from config");
    a_rate_reset: assert property (
        $rose(hresetn) |-> machine_rate_select == 2'h1)
        else $error("rate select not 26 Hz code");
    a_tick_period: assert property (
        eval_tick && tcnt == 2'h2 && !chg |-> gap == 24'(cyc - 1))
        else $error("tick period wrong");
    a_tick_pulse: assert property (
        eval_tick |=> !eval_tick)
        else $error("tick longer than a cycle");
    a_irq_cause: assert property (
        $rose(irq) |-> $past(eng_done, 2) || $past(wr, 3))
        else $error("irq rose without cause");
endmodule : smr_result_regs_props
bind smr_result_regs smr_result_regs_props #(
    .CYC_00(CYC_00),
    .CYC_01(CYC_01),
    .CYC_10(CYC_10),
    .CYC_11(CYC_11)
) u_smr_result_regs_props (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .eng_flags(eng_flags),
    .eng_done(eng_done), .eval_tick(eval_tick),
    .machine_rate_select(machine_rate_select), .irq(irq)
);
`default_nettype wire

// >>> dv/smr_result_regs_tb_top.sv
// Self-checking bench for the result register bank.
// Assumes the package, design and checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module smr_result_regs_tb_top;
    // ----------
    // Signals and instance
    // ----------
    localparam int unsigned CYC [4] = '{20, 10, 6, 4};
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [smr_pkg::ADDR_W-1:0] haddr = '0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [47:0] eng_flags = 48'h0;
    logic eng_done = 1'b0;
    wire logic hready, hreadyout, hresp, eval_tick, irq;
    wire logic [31:0] hrdata;
    wire logic [1:0] machine_rate_select;
    int n_fail = 0;
    int cmp_count = 0;
    assign hready = hreadyout;
    smr_result_regs #(
        .CYC_00(CYC[0]), .CYC_01(CYC[1]),
        .CYC_10(CYC[2]), .CYC_11(CYC[3])
    ) u_smr_result_regs (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .eng_flags(eng_flags),
        .eng_done(eng_done), .eval_tick(eval_tick),
        .machine_rate_select(machine_rate_select), .irq(irq)
    );
    initial begin
        forever #12.5 hclk = ~hclk;
    end
    // ----------
    // Shared tasks
    // ----------
    function automatic logic [9:0] ra(input logic [7:0] i);
        return {i, 2'h0};
    endfunction : ra
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch at %0t seen %h expected %h", $time, s, e);
        end
    endtask : check
    task automatic bus(input logic w, input logic [9:0] a,
        input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= smr_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask : bus
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd_chk(input logic [9:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, e);
        check({31'h0, hresp}, {31'h0, smr_pkg::HRESP_OKAY});
    endtask : rd_chk
    task automatic eng(input logic [47:0] f);
        eng_flags <= f;
        eng_done <= 1'b1;
        @(posedge hclk);
        eng_flags <= ~f;
        eng_done <= 1'b0;
        @(posedge hclk);
    endtask : eng
    task automatic wait_tick(output int n);
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (eval_tick !== 1'b1 && n < 200);
    endtask : wait_tick
    task automatic do_reset;
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
    endtask : do_reset
    // ----------
    // Scenarios
    // ----------
    task automatic t_reset;
        for (int i = 0; i < 6; i++)
            rd_chk(ra(8'h56 + 8'(i)), 32'h0);
        rd_chk(ra(8'h5F), 32'h1);
        check({30'h0, machine_rate_select}, 32'h1);
        check({31'h0, irq}, 32'h0);
        check({31'h0, hreadyout}, 32'h1);
        $display("test reset done");
    endtask : t_reset
    task automatic t_flags;
        logic [47:0] f;
        for (int b = 0; b < 8; b++) begin
            for (int i = 0; i < 6; i++)
                f[8*i +: 8] = 8'h01 << ((b + i) % 8);
            eng(f);
            for (int i = 0; i < 6; i++)
                rd_chk(ra(8'h56 + 8'(i)), {24'h0, f[8*i +: 8]});
        end
        wr(ra(8'h56), 32'hFF);
        rd_chk(ra(8'h56), {24'h0, f[7:0]});
        wr(10'h100, 32'hFF);
        rd_chk(10'h100, 32'h0);
        $display("test flags done");
    endtask : t_flags
    task automatic t_rate;
        int n;
        for (int c = 0; c < 4; c++) begin
            wr(ra(8'h5F), 32'(c));
            rd_chk(ra(8'h5F), 32'(c));
            check({30'h0, machine_rate_select}, 32'(c));
            repeat (3) wait_tick(n);
            check(32'(n), CYC[c]);
        end
        wr(ra(8'h5F), 32'h1);
        $display("test rate done");
    endtask : t_rate
    task automatic t_irq;
        eng(48'h0);
        wr(ra(smr_pkg::IDX_IRQ_STAT), 32'h3F);
        rd_chk(ra(smr_pkg::IDX_IRQ_STAT), 32'h0);
        eng(48'h000000040000);
        rd_chk(ra(smr_pkg::IDX_IRQ_STAT), 32'h4);
        check({31'h0, irq}, 32'h0);
        wr(ra(smr_pkg::IDX_IRQ_MASK), 32'h4);
        repeat (2) @(posedge hclk);
        check({31'h0, irq}, 32'h1);
        wr(ra(smr_pkg::IDX_IRQ_STAT), 32'h4);
        repeat (2) @(posedge hclk);
        check({31'h0, irq}, 32'h0);
        $display("test irq done");
    endtask : t_irq
    task automatic finish_test;
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test
    initial begin
        do_reset;
        t_reset;
        t_flags;
        t_rate;
        t_irq;
        wr(ra(8'h5F), 32'h3);
        do_reset;
        t_reset;
        finish_test;
    end
    // Run needs about 320 cycles; allow 10000, some thirty times that
    initial begin
        #(25 * 10000);
        n_fail++;
        finish_test;
    end
endmodule : smr_result_regs_tb_top
`default_nettype wire
